/* core/lpw_wake_ctrl.sv */
// Idle/deep-sleep entry, oscillator gating and wake-up sequencing
//
// The plain strobed port was chosen for this implementation.
module lpw_wake_ctrl
	import lpw_pkg::*;
#(
	parameter int STAB_COUNT = STAB_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Core instruction interface
	input wire logic idle_instr,
	input wire logic deep_instr,
	input wire logic [1:0] core_context,
	input wire logic nmi_ack,
	input wire logic resume_ack,
	// Reset sources and hardware watchdog enable (pins, asynchronous)
	input wire logic ext_reset_pin,
	input wire logic watchdog_reset,
	input wire logic hw_watchdog_on,
	// Interrupt events
	input wire logic nmi_pin,
	input wire logic src1_req,
	input wire logic src2_req,
	input wire logic timer_zero_flag,
	input wire logic converter_eoc_flag,
	input wire logic reload_overflow_flag,
	input wire logic reload_compare_flag,
	input wire logic reload_edge_flag,
	input wire logic rx_byte_flag,
	input wire logic tx_byte_flag,
	// Power control and resume outputs
	output logic core_halt,
	output logic osc_enable,
	output logic reset_request,
	output logic [2:0] resume_action,
	output logic [4:0] irq_vector,
	output logic wake_pulse
);
	lpw_state_e state_q, state_d;
	logic [7:0] interrupt_option_q;
	logic [7:0] timer_status_control_q;
	logic [7:0] converter_control_q;
	logic [7:0] reload_timer_mode_control_q;
	logic [7:0] serial_control_q;
	logic [7:0] wake_config_q;
	logic [1:0] sleep_ctx_q;
	logic [STAB_W-1:0] stab_cnt_q;
	logic nmi_latch_q;
	logic nmi_woke_q;
	logic [1:0] nmi_sync_q, rst_sync_q, wdg_sync_q, hwd_sync_q;
	logic nmi_prev_q;
	logic [2:0] resume_q;
	logic [4:0] vector_q;
	logic wake_q;
	logic halt_q, osc_q, rst_q;
	logic [7:0] rdata_q;

	// Two-stage synchronisers for pin-level inputs
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			nmi_sync_q <= 2'h0;
			rst_sync_q <= 2'h0;
			wdg_sync_q <= 2'h0;
			hwd_sync_q <= 2'h0;
		end else begin
			nmi_sync_q <= {nmi_sync_q[0], nmi_pin};
			rst_sync_q <= {rst_sync_q[0], ext_reset_pin};
			wdg_sync_q <= {wdg_sync_q[0], watchdog_reset};
			hwd_sync_q <= {hwd_sync_q[0], hw_watchdog_on};
		end
	end

	// Enable bit of an 8-bit control register
	function automatic logic en_bit(input logic [7:0] r, input int pos);
		return r[pos[2:0]];
	endfunction

	logic global_irq_enable;
	logic [4:1] mask_req;
	logic any_masked;
	logic wake_req;
	logic watchdog_active;
	logic reset_in;
	logic nmi_rise;

	assign global_irq_enable = en_bit(interrupt_option_q,
		GLOBAL_IRQ_ENABLE_BIT);
	assign reset_in = rst_sync_q[1] | wdg_sync_q[1];
	assign nmi_rise = nmi_sync_q[1] & ~nmi_prev_q;
	assign watchdog_active = hwd_sync_q[1] | en_bit(wake_config_q,
		SW_WATCHDOG_BIT);

	always_comb begin
		mask_req[1] = src1_req;
		mask_req[2] = src2_req;
		mask_req[3] = (timer_zero_flag &
			en_bit(timer_status_control_q, TIMER_IRQ_ENABLE_BIT)) |
			(reload_overflow_flag & en_bit(reload_timer_mode_control_q,
			RELOAD_OVERFLOW_IRQ_ENABLE_BIT)) |
			(reload_compare_flag & en_bit(reload_timer_mode_control_q,
			RELOAD_COMPARE_IRQ_ENABLE_BIT)) |
			(reload_edge_flag & en_bit(reload_timer_mode_control_q,
			RELOAD_EDGE_IRQ_ENABLE_BIT));
		mask_req[4] = (converter_eoc_flag &
			en_bit(converter_control_q, CONVERTER_IRQ_ENABLE_BIT)) |
			(rx_byte_flag & en_bit(serial_control_q, RX_IRQ_ENABLE_BIT)) |
			(tx_byte_flag & en_bit(serial_control_q, TX_IRQ_ENABLE_BIT));
		any_masked = global_irq_enable & (|mask_req);
		// Wake request, none without global enable
		wake_req = global_irq_enable & ((|mask_req) | nmi_latch_q);
	end

	// Register writes; interrupt option is write-only
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			interrupt_option_q <= REG_RESET;
			timer_status_control_q <= REG_RESET;
			converter_control_q <= REG_RESET;
			reload_timer_mode_control_q <= REG_RESET;
			serial_control_q <= REG_RESET;
			wake_config_q <= WAKE_CONFIG_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
				INTERRUPT_OPTION_ADDR: interrupt_option_q <= reg_wdata;
				TIMER_STATUS_CONTROL_ADDR: timer_status_control_q <= reg_wdata;
				CONVERTER_CONTROL_ADDR: converter_control_q <= reg_wdata;
				RELOAD_TIMER_MODE_CONTROL_ADDR:
					reload_timer_mode_control_q <= reg_wdata;
				SERIAL_CONTROL_ADDR: serial_control_q <= reg_wdata;
				WAKE_CONFIG_ADDR: wake_config_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Register reads, data in the following cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				TIMER_STATUS_CONTROL_ADDR: rdata_q <= timer_status_control_q;
				CONVERTER_CONTROL_ADDR: rdata_q <= converter_control_q;
				RELOAD_TIMER_MODE_CONTROL_ADDR:
					rdata_q <= reload_timer_mode_control_q;
				SERIAL_CONTROL_ADDR: rdata_q <= serial_control_q;
				WAKE_CONFIG_ADDR: rdata_q <= wake_config_q;
				WAKE_STATUS_ADDR: rdata_q <= {3'h0, state_q};
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// Non-maskable latch; a new edge wins over the core's clear
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			nmi_prev_q <= 1'b0;
			nmi_latch_q <= 1'b0;
		end else begin
			nmi_prev_q <= nmi_sync_q[1];
			if (nmi_rise)
				nmi_latch_q <= 1'b1;
			else if (nmi_ack)
				nmi_latch_q <= 1'b0;
		end
	end

	// Sleep sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			LPW_RUN: begin
				if (!any_masked && !nmi_latch_q) begin
					// Watchdog turns deep sleep into idle
					if (deep_instr && !watchdog_active)
						state_d = LPW_DEEP;
					else if (idle_instr || deep_instr)
						state_d = LPW_IDLE;
				end
			end
			LPW_IDLE: if (wake_req) state_d = LPW_RESUME;
			LPW_DEEP: if (wake_req) state_d = LPW_STAB;
			LPW_STAB:
				if (stab_cnt_q == STAB_W'(STAB_COUNT - 1))
					state_d = LPW_RESUME;
			LPW_RESUME: if (resume_ack) state_d = LPW_RUN;
			default: state_d = LPW_RUN;
		endcase
		if (reset_in)
			state_d = LPW_RUN;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			state_q <= LPW_RUN;
		else
			state_q <= state_d;
	end

	// Stabilisation counter
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			stab_cnt_q <= '0;
		else if (state_q == LPW_STAB)
			stab_cnt_q <= stab_cnt_q + STAB_W'(1);
		else
			stab_cnt_q <= '0;
	end

	// Context captured at sleep entry and waking source
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sleep_ctx_q <= CTX_NORMAL;
			nmi_woke_q <= 1'b0;
		end else begin
			if (state_q == LPW_RUN && state_d != LPW_RUN)
				sleep_ctx_q <= core_context;
			if ((state_q == LPW_IDLE || state_q == LPW_DEEP) && wake_req)
				nmi_woke_q <= nmi_latch_q;
		end
	end

	// Resume decision and vector
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			resume_q <= RES_NONE;
			vector_q <= 5'h00;
		end else if (state_d == LPW_RESUME && state_q != LPW_RESUME) begin
			case (sleep_ctx_q)
				CTX_NMI: begin
					resume_q <= RES_NEXT;
					vector_q <= 5'h00;
				end
				CTX_MASKABLE: begin
					if (state_q == LPW_STAB ? nmi_woke_q :
						nmi_latch_q) begin
						resume_q <= RES_NMI_THEN_NEXT;
						vector_q <= 5'h01;
					end else begin
						resume_q <= RES_NEXT;
						vector_q <= 5'h00;
					end
				end
				default: begin
					resume_q <= RES_ISR_THEN_NEXT;
					vector_q <= prio_vec(nmi_latch_q, mask_req);
				end
			endcase
		end else if (state_d != LPW_RESUME) begin
			resume_q <= RES_NONE;
			vector_q <= 5'h00;
		end
	end

	// Fixed priority, non-maskable above source 1
	function automatic logic [4:0] prio_vec(input logic nmi,
		input logic [4:1] m);
		if (nmi)
			return 5'h01;
		else if (m[1])
			return 5'h02;
		else if (m[2])
			return 5'h04;
		else if (m[3])
			return 5'h08;
		else if (m[4])
			return 5'h10;
		else
			return 5'h00;
	endfunction

	// Power outputs
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			halt_q <= 1'b0;
			osc_q <= 1'b1;
			rst_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			// Halt in idle, also in deep sleep and stabilisation
			halt_q <= state_d == LPW_IDLE || state_d == LPW_DEEP ||
				state_d == LPW_STAB;
			// Oscillator gated only in deep sleep
			// Wake restarts same oscillator, selection untouched
			osc_q <= state_d != LPW_DEEP;
			rst_q <= reset_in;
			wake_q <= (state_q == LPW_IDLE || state_q == LPW_DEEP) &&
				wake_req && !reset_in;
		end
	end

	assign reg_rdata = rdata_q;
	assign core_halt = halt_q;
	assign osc_enable = osc_q;
	assign reset_request = rst_q;
	assign resume_action = resume_q;
	assign irq_vector = vector_q;
	assign wake_pulse = wake_q;
endmodule

/* shared/lpw_pkg.sv */
// Constants and types for the low-power wake controller
package lpw_pkg;
	localparam logic [7:0] INTERRUPT_OPTION_ADDR = 8'hc8;
	localparam logic [7:0] TIMER_STATUS_CONTROL_ADDR = 8'hd4;
	localparam logic [7:0] CONVERTER_CONTROL_ADDR = 8'hd1;
	localparam logic [7:0] RELOAD_TIMER_MODE_CONTROL_ADDR = 8'he5;
	localparam logic [7:0] SERIAL_CONTROL_ADDR = 8'hd7;
	localparam logic [7:0] WAKE_STATUS_ADDR = 8'hf0;
	localparam logic [7:0] WAKE_CONFIG_ADDR = 8'hf1;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] WAKE_CONFIG_RESET = 8'h00;
	// Bit positions
	localparam int GLOBAL_IRQ_ENABLE_BIT = 4;
	localparam int TIMER_IRQ_ENABLE_BIT = 4;
	localparam int CONVERTER_IRQ_ENABLE_BIT = 4;
	localparam int RELOAD_OVERFLOW_IRQ_ENABLE_BIT = 0;
	localparam int RELOAD_COMPARE_IRQ_ENABLE_BIT = 1;
	localparam int RELOAD_EDGE_IRQ_ENABLE_BIT = 2;
	localparam int RX_IRQ_ENABLE_BIT = 0;
	localparam int TX_IRQ_ENABLE_BIT = 1;
	localparam int SW_WATCHDOG_BIT = 0;
	// Oscillator stabilisation
	localparam int STAB_TIME_US = 2048;
	localparam int CLK_MHZ = 100;
	localparam int STAB_CYCLES = STAB_TIME_US * CLK_MHZ;
	localparam int STAB_W = 20;
	// Processor context at sleep entry
	localparam logic [1:0] CTX_NORMAL = 2'h0;
	localparam logic [1:0] CTX_MASKABLE = 2'h1;
	localparam logic [1:0] CTX_NMI = 2'h2;
	// Resume actions reported to the core
	localparam logic [2:0] RES_NONE = 3'h0;
	localparam logic [2:0] RES_NEXT = 3'h1;
	localparam logic [2:0] RES_ISR_THEN_NEXT = 3'h2;
	localparam logic [2:0] RES_NMI_THEN_NEXT = 3'h3;
	typedef enum logic [4:0] {
		LPW_RUN = 5'b00001,
		LPW_IDLE = 5'b00010,
		LPW_DEEP = 5'b00100,
		LPW_STAB = 5'b01000,
		LPW_RESUME = 5'b10000
	} lpw_state_e;
endpackage

/* test/lpw_wake_ctrl_assertions.sv */
// Port checker for the wake controller
module lpw_wake_chk
	import lpw_pkg::*;
#(
	parameter int STAB_COUNT = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Core side
	input wire logic [1:0] core_context,
	input wire logic resume_ack,
	input wire logic ext_reset_pin,
	// Power outputs
	input wire logic core_halt,
	input wire logic osc_enable,
	input wire logic reset_request,
	input wire logic [2:0] resume_action,
	input wire logic [4:0] irq_vector,
	input wire logic wake_pulse
);
	localparam int STAB_M1 = STAB_COUNT - 1;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_stab;
		1'b1 ##STAB_M1 1'b1;
	endsequence
	property p_deep_osc;
		!osc_enable |-> core_halt;
	endproperty
	a_deep_osc: assert property (p_deep_osc)
		else $error("osc off in run");
	property p_stab;
		$rose(osc_enable) && !reset_request |->
			(core_halt || reset_request) throughout s_stab;
	endproperty
	a_stab: assert property (p_stab)
		else $error("stab cut short");
	property p_idle_fast;
		wake_pulse && $past(osc_enable) |-> !core_halt;
	endproperty
	a_idle_fast: assert property (p_idle_fast)
		else $error("idle wake delayed");
	property p_wake_one;
		wake_pulse |=> !wake_pulse;
	endproperty
	a_wake_one: assert property (p_wake_one)
		else $error("wake pulse long");
	property p_reset_req;
		$rose(ext_reset_pin) |-> ##[2:3] reset_request;
	endproperty
	a_reset_req: assert property (p_reset_req)
		else $error("reset request late");
	property p_hold;
		resume_action != RES_NONE && !resume_ack |=> $stable(resume_action);
	endproperty
	a_hold: assert property (p_hold)
		else $error("resume not held");
	property p_nmi_ctx;
		$fell(core_halt) && core_context == CTX_NMI && !reset_request
			|-> ##[0:1] resume_action == RES_NEXT;
	endproperty
	a_nmi_ctx: assert property (p_nmi_ctx)
		else $error("nmi context resume");
	property p_vec_one;
		$onehot0(irq_vector);
	endproperty
	a_vec_one: assert property (p_vec_one)
		else $error("vector not one-hot");
endmodule

bind lpw_wake_ctrl lpw_wake_chk #(.STAB_COUNT(STAB_COUNT)) chk (
	.core_clk, .rstn, .core_context, .resume_ack, .ext_reset_pin,
	.core_halt, .osc_enable, .reset_request, .resume_action,
	.irq_vector, .wake_pulse);

/* test/lpw_core_model.sv */
// Core model acknowledging each resume after a delay
module lpw_core_model #(
	parameter int DLY = 3
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Controller side
	input wire logic [2:0] resume_action,
	input wire logic [4:0] irq_vector,
	output logic resume_ack,
	output logic nmi_ack
);
	int cnt_q;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 0;
		end else if (resume_action == 3'h0 || resume_ack) begin
			cnt_q <= 0;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
	assign resume_ack = cnt_q == DLY;
	assign nmi_ack = resume_ack && irq_vector[0];
endmodule

/* test/tb_low_power_wake_control.sv */
// Self-checking bench for the wake controller
module tb_low_power_wake_control import lpw_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, nmi_pin = 0;
	logic idle_instr = 0, deep_instr = 0, hw_watchdog_on = 0, sw_wdg = 0;
	logic ext_reset_pin = 0, watchdog_reset = 0, nmi_ack, resume_ack;
	logic core_halt, osc_enable, reset_request, wake_pulse;
	logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, d;
	logic [1:0] core_context = '0;
	logic [2:0] resume_action;
	logic [4:0] irq_vector;
	logic [8:0] ev = '0;
	int err_total = 0, comparisons = 0, cyc = 0;
	lpw_wake_ctrl #(.STAB_COUNT(8)) dut (.core_clk, .rstn, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .idle_instr, .deep_instr,
		.core_context, .nmi_ack, .resume_ack, .ext_reset_pin,
		.watchdog_reset, .hw_watchdog_on, .nmi_pin, .src1_req(ev[7]),
		.src2_req(ev[8]), .timer_zero_flag(ev[0]),
		.converter_eoc_flag(ev[1]), .reload_overflow_flag(ev[2]),
		.reload_compare_flag(ev[3]), .reload_edge_flag(ev[4]),
		.rx_byte_flag(ev[5]), .tx_byte_flag(ev[6]), .core_halt,
		.osc_enable, .reset_request, .resume_action, .irq_vector,
		.wake_pulse);
	lpw_core_model #(.DLY(3)) core (.core_clk, .rstn, .resume_action,
		.irq_vector, .resume_ack, .nmi_ack);
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end
	task automatic summarize();
		$display("Checks %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s exp %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, output logic [7:0] v);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		v = reg_rdata;
	endtask
	task automatic sleep(logic dp);
		@(posedge core_clk);
		idle_instr <= !dp;
		deep_instr <= dp;
		@(posedge core_clk);
		idle_instr <= 1'b0;
		deep_instr <= 1'b0;
		@(negedge core_clk);
	endtask
	task automatic nowake(logic [8:0] e);
		ev <= e;
		repeat (12) @(negedge core_clk);
		chk("nowake", core_halt, 1'b1);
		ev <= '0;
	endtask
	// Sleep unless halted, raise events, judge the resume
	task automatic wake(logic dp, logic [1:0] cx, logic [8:0] e,
		logic nm, logic [2:0] act, logic [4:0] vec);
		int n = 0;
		logic dd;
		dd = dp & ~hw_watchdog_on & ~sw_wdg;
		if (!core_halt) begin
			core_context <= cx;
			sleep(dp);
			chk("halt", core_halt, 1'b1);
			chk("osc", osc_enable, !dd);
		end
		ev <= e;
		nmi_pin <= nm;
		while (core_halt && n < 40) begin
			@(negedge core_clk);
			n++;
		end
		chk("delay", dd ? n > 8 : n == 1 || nm, 1'b1);
		chk("pulse", wake_pulse, !dd);
		chk("act", resume_action, act);
		if (vec != 5'h1f)
			chk("vec", irq_vector, vec);
		ev <= '0;
		nmi_pin <= 1'b0;
		repeat (6) @(negedge core_clk);
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		@(negedge core_clk);
		chk("osc", osc_enable, 1'b1);
		rd(INTERRUPT_OPTION_ADDR, d);
		chk("int_opt", d, 8'h00);
		rd(8'h10, d);
		chk("unmapped", d, 8'h00);
		wr(TIMER_STATUS_CONTROL_ADDR, 8'h10);
		rd(TIMER_STATUS_CONTROL_ADDR, d);
		chk("tsc", d, 8'h10);
		wr(CONVERTER_CONTROL_ADDR, 8'h10);
		wr(SERIAL_CONTROL_ADDR, 8'h03);
		wr(RELOAD_TIMER_MODE_CONTROL_ADDR, 8'h06);
		wr(INTERRUPT_OPTION_ADDR, 8'h10);
		// Overflow masked off, compare still wakes
		sleep(1'b0);
		nowake(9'h004);
		rd(WAKE_STATUS_ADDR, d);
		chk("status", d, 8'h02);
		wake(1'b0, CTX_NORMAL, 9'h008, 1'b0, RES_ISR_THEN_NEXT, 5'h08);
		wr(RELOAD_TIMER_MODE_CONTROL_ADDR, 8'h07);
		for (int i = 0; i < 7; i++)
			wake(i == 1, CTX_NORMAL, 9'(1 << i), 1'b0, RES_ISR_THEN_NEXT,
				(i == 1 || i > 4) ? 5'h10 : 5'h08);
		wake(1'b0, CTX_NORMAL, 9'h181, 1'b0, RES_ISR_THEN_NEXT, 5'h02);
		wake(1'b0, CTX_NMI, 9'h001, 1'b0, RES_NEXT, 5'h1f);
		wake(1'b0, CTX_MASKABLE, 9'h020, 1'b0, RES_NEXT, 5'h1f);
		wake(1'b1, CTX_MASKABLE, 9'h000, 1'b1, RES_NMI_THEN_NEXT, 5'h01);
		hw_watchdog_on <= 1'b1;
		repeat (3) @(negedge core_clk);
		wake(1'b1, CTX_NORMAL, 9'h040, 1'b0, RES_ISR_THEN_NEXT, 5'h10);
		hw_watchdog_on <= 1'b0;
		// Software watchdog also turns deep sleep into idle
		wr(WAKE_CONFIG_ADDR, 8'h01);
		rd(WAKE_CONFIG_ADDR, d);
		chk("wcfg", d, 8'h01);
		sw_wdg = 1'b1;
		wake(1'b1, CTX_NORMAL, 9'h020, 1'b0, RES_ISR_THEN_NEXT, 5'h10);
		sw_wdg = 1'b0;
		wr(WAKE_CONFIG_ADDR, 8'h00);
		ev <= 9'h001;
		sleep(1'b0);
		chk("pend", core_halt, 1'b0);
		ev <= '0;
		// Watchdog reset during deep sleep
		sleep(1'b1);
		chk("deep", osc_enable, 1'b0);
		watchdog_reset <= 1'b1;
		repeat (5) @(negedge core_clk);
		chk("wrst", reset_request, 1'b1);
		chk("whalt", core_halt, 1'b0);
		chk("wosc", osc_enable, 1'b1);
		watchdog_reset <= 1'b0;
		repeat (5) @(negedge core_clk);
		chk("wrel", reset_request, 1'b0);
		wr(INTERRUPT_OPTION_ADDR, 8'h00);
		sleep(1'b0);
		nowake(9'h001);
		nmi_pin <= 1'b1;
		nowake(9'h000);
		ext_reset_pin <= 1'b1;
		repeat (5) @(negedge core_clk);
		chk("rst", reset_request, 1'b1);
		chk("rhalt", core_halt, 1'b0);
		ext_reset_pin <= 1'b0;
		summarize();
	end
endmodule
